// ---- axis_bank.sv ----
// Behaviour
// [RULE_01] Forward jog bit 2 fetched each main cycle; axis jogs forward while set.
// [RULE_02] Reverse jog bit 3 fetched each main cycle; axis jogs reverse while set.
// [RULE_03] Bit 4 sampled each main cycle clears the axis completion flags; code re-sets position complete in that cycle if motion done is high.
// [RULE_04] Bit 8 sampled each main cycle clears the axis servo error status.
// [RULE_05] Bit 9 latched at start; when set the external stop is ignored.
// [RULE_06] Bit 12 sampled only at start requests a feed value update.
// [RULE_07] Bit 13 sampled only on entry into virtual mode.
// [RULE_08] Bit 14 sampled only on entry into virtual mode.
// [RULE_09] Host does not use bits 13 and 14 in real mode.
// [RULE_10] Control loop bit 18 fetched every operation cycle.
// [RULE_11] Gain bit 16 fetched each operation cycle, every 3.5 ms when cycle is long.
// [RULE_12] Only axes 1 to 8 exist; blocks of axis 9 and above unusable.
// [RULE_13] Per-axis blocks at fixed stride; status per cycle, errors set immediately; code sets the servo error status only on an operation cycle.
// [RULE_14] Host keeps unusable command bits 6, 10, 11 and 17 at zero.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
module axis_bank #(
  parameter int BASE_TICK_CYC = axis_bank_pkg::BASE_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [axis_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [axis_bank_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [axis_bank_pkg::NAXES-1:0] upper_stroke_limit_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] lower_stroke_limit_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] stop_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] proximity_or_switch_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] servo_ready_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] servo_alarm_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] fault_input,
  input wire logic [axis_bank_pkg::NAXES-1:0] motion_done_input,
  output logic [axis_bank_pkg::NAXES-1:0] jog_forward,
  output logic [axis_bank_pkg::NAXES-1:0] jog_reverse,
  output logic [axis_bank_pkg::NAXES-1:0] stop_request,
  output logic [axis_bank_pkg::NAXES-1:0] feed_update,
  output logic [axis_bank_pkg::NAXES-1:0] clutch_ref_set,
  output logic [axis_bank_pkg::NAXES-1:0] cam_ref_set,
  output logic [axis_bank_pkg::NAXES-1:0] gain_select,
  output logic [axis_bank_pkg::NAXES-1:0] loop_select,
  output logic irq
);
  localparam logic [axis_bank_pkg::BASE_CNT_W-1:0] BASE_LAST =
    axis_bank_pkg::BASE_CNT_W'(BASE_TICK_CYC - 1);

  typedef struct packed {
    logic [axis_bank_pkg::ADDR_W-1:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic virt;
    logic [axis_bank_pkg::SEL_W-1:0] op_sel;
    logic virt_d;
    logic [axis_bank_pkg::NAXES-1:0] start;
    logic [axis_bank_pkg::NAXES-1:0] irq_stat;
    logic [axis_bank_pkg::NAXES-1:0] irq_mask;
    logic irq;
    logic [axis_bank_pkg::NAXES-1:0][axis_bank_pkg::BLK_W-1:0] cmd;
    logic [axis_bank_pkg::BASE_CNT_W-1:0] base_cnt;
    logic [axis_bank_pkg::TICK_W-1:0] tick_cnt;
    logic op_tick;
    logic main_tick;
    logic gain_tick;
    logic virt_enter;
  } bank_t;

  bank_t s_reg;
  bank_t s_next;
  logic [axis_bank_pkg::NAXES-1:0][axis_bank_pkg::BLK_W-1:0] stat_w;
  logic [axis_bank_pkg::NAXES-1:0] err_w;

  axis_link_if lk [axis_bank_pkg::NAXES] ();

  genvar g;
  generate
    for (g = 0; g < axis_bank_pkg::NAXES; g++) begin : g_axis
      assign lk[g].cmd = s_reg.cmd[g];
      assign lk[g].op_tick = s_reg.op_tick;
      assign lk[g].main_tick = s_reg.main_tick;
      assign lk[g].gain_tick = s_reg.gain_tick;
      assign lk[g].virt_enter = s_reg.virt_enter;
      assign lk[g].start = s_reg.start[g];
      assign stat_w[g] = lk[g].status;
      assign err_w[g] = lk[g].err_evt;
      axis_unit u_axis (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk[g]),
        .pins({motion_done_input[g], fault_input[g], servo_alarm_input[g],
          servo_ready_input[g], proximity_or_switch_input[g], stop_input[g],
          lower_stroke_limit_input[g], upper_stroke_limit_input[g]}),
        .jog_fwd(jog_forward[g]),
        .jog_rev(jog_reverse[g]),
        .stop_req(stop_request[g]),
        .feed_upd(feed_update[g]),
        .clutch_ref(clutch_ref_set[g]),
        .cam_ref(cam_ref_set[g]),
        .gain_sel(gain_select[g]),
        .loop_sel(loop_select[g])
      );
    end
  endgenerate

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic in_region(input logic [axis_bank_pkg::ADDR_W-1:0] a,
    input logic [axis_bank_pkg::ADDR_W-1:0] base);
    return a[axis_bank_pkg::ADDR_W-1:axis_bank_pkg::REGION_LSB]
      == base[axis_bank_pkg::ADDR_W-1:axis_bank_pkg::REGION_LSB];
  endfunction

  logic [axis_bank_pkg::IDX_W-1:0] w_idx;
  logic [axis_bank_pkg::IDX_W-1:0] r_idx;
  logic [31:0] wmask;
  logic [axis_bank_pkg::TICK_W-1:0] sel_mask;
  logic [axis_bank_pkg::SEL_W-1:0] wr_sel;
  logic [axis_bank_pkg::TICK_W-1:0] next_tick;
  logic base_tick;

  always_comb begin
    s_next = s_reg;
    w_idx = s_reg.awaddr[2 +: axis_bank_pkg::IDX_W];
    r_idx = s_axi_araddr[2 +: axis_bank_pkg::IDX_W];
    wmask = strb_mask(s_reg.wstrb);
    wr_sel = '0;
    s_next.start = '0;
    s_next.op_tick = 1'b0;
    s_next.main_tick = 1'b0;
    s_next.gain_tick = 1'b0;

    // Time base
    base_tick = (s_reg.base_cnt == BASE_LAST);
    next_tick = s_reg.tick_cnt + 1'b1;
    sel_mask = axis_bank_pkg::TICK_W'((1 << s_reg.op_sel) - 1);
    if (base_tick) begin
      s_next.base_cnt = '0;
      s_next.tick_cnt = next_tick;
      s_next.op_tick = ((next_tick & sel_mask) == '0);
      s_next.main_tick = ((next_tick & axis_bank_pkg::MAIN_MASK) == '0);
      if (s_reg.op_sel >= axis_bank_pkg::SEL_SLOW) begin
        s_next.gain_tick = // see [RULE_11]
          ((next_tick[axis_bank_pkg::SEL_W-1:0] & axis_bank_pkg::SLOW_MASK) == '0);
      end else begin
        s_next.gain_tick = s_next.op_tick;
      end
    end else begin
      s_next.base_cnt = s_reg.base_cnt + 1'b1;
    end
    s_next.virt_d = s_reg.virt;
    s_next.virt_enter = s_reg.virt & ~s_reg.virt_d; // see [RULE_07]

    // Write channel
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awaddr = s_axi_awaddr;
      s_next.aw_held = 1'b1;
      s_next.awready = 1'b0;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
      s_next.w_held = 1'b1;
      s_next.wready = 1'b0;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = axis_bank_pkg::RESP_OKAY;
      if (s_reg.awaddr == axis_bank_pkg::CTRL_OFS) begin
        if (s_reg.wstrb[0]) begin
          s_next.virt = s_reg.wdata[axis_bank_pkg::CTRL_VIRT_BIT];
          wr_sel = s_reg.wdata[axis_bank_pkg::CTRL_SEL_LSB +: axis_bank_pkg::SEL_W];
          s_next.op_sel = (wr_sel > axis_bank_pkg::SEL_MAX) ? axis_bank_pkg::SEL_MAX : wr_sel;
        end
      end else if (s_reg.awaddr == axis_bank_pkg::START_OFS) begin
        s_next.start = s_reg.wdata[axis_bank_pkg::NAXES-1:0] & wmask[axis_bank_pkg::NAXES-1:0];
      end else if (s_reg.awaddr == axis_bank_pkg::IRQ_STAT_OFS) begin
        s_next.irq_stat = s_reg.irq_stat
          & ~(s_reg.wdata[axis_bank_pkg::NAXES-1:0] & wmask[axis_bank_pkg::NAXES-1:0]);
      end else if (s_reg.awaddr == axis_bank_pkg::IRQ_MASK_OFS) begin
        s_next.irq_mask = (s_reg.irq_mask & ~wmask[axis_bank_pkg::NAXES-1:0])
          | (s_reg.wdata[axis_bank_pkg::NAXES-1:0] & wmask[axis_bank_pkg::NAXES-1:0]);
      end else if (in_region(s_reg.awaddr, axis_bank_pkg::CMD_BASE)
        && s_reg.awaddr[1:0] == 2'h0) begin
        if (w_idx < axis_bank_pkg::NAXES) begin // see [RULE_13]
          s_next.cmd[w_idx[2:0]] = (s_reg.cmd[w_idx[2:0]] & ~wmask[axis_bank_pkg::BLK_W-1:0])
            | (s_reg.wdata[axis_bank_pkg::BLK_W-1:0] & wmask[axis_bank_pkg::BLK_W-1:0]);
        end
      end else if (!(in_region(s_reg.awaddr, axis_bank_pkg::STAT_BASE)
        && s_reg.awaddr[1:0] == 2'h0)) begin
        s_next.bresp = axis_bank_pkg::RESP_SLVERR;
      end
    end

    // Interrupts: hardware set wins over software clear
    s_next.irq_stat = s_next.irq_stat | err_w;
    s_next.irq = |(s_reg.irq_stat & s_reg.irq_mask);

    // Read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      s_next.rresp = axis_bank_pkg::RESP_OKAY;
      if (s_axi_araddr == axis_bank_pkg::CTRL_OFS) begin
        s_next.rdata[axis_bank_pkg::CTRL_VIRT_BIT] = s_reg.virt;
        s_next.rdata[axis_bank_pkg::CTRL_SEL_LSB +: axis_bank_pkg::SEL_W] = s_reg.op_sel;
      end else if (s_axi_araddr == axis_bank_pkg::START_OFS) begin
        s_next.rdata = '0;
      end else if (s_axi_araddr == axis_bank_pkg::IRQ_STAT_OFS) begin
        s_next.rdata[axis_bank_pkg::NAXES-1:0] = s_reg.irq_stat;
      end else if (s_axi_araddr == axis_bank_pkg::IRQ_MASK_OFS) begin
        s_next.rdata[axis_bank_pkg::NAXES-1:0] = s_reg.irq_mask;
      end else if (in_region(s_axi_araddr, axis_bank_pkg::CMD_BASE)
        && s_axi_araddr[1:0] == 2'h0) begin
        if (r_idx < axis_bank_pkg::NAXES) begin // see [RULE_12]
          s_next.rdata[axis_bank_pkg::BLK_W-1:0] = s_reg.cmd[r_idx[2:0]];
        end
      end else if (in_region(s_axi_araddr, axis_bank_pkg::STAT_BASE)
        && s_axi_araddr[1:0] == 2'h0) begin
        if (r_idx < axis_bank_pkg::NAXES) begin // see [RULE_12]
          s_next.rdata[axis_bank_pkg::BLK_W-1:0] = stat_w[r_idx[2:0]];
        end
      end else begin
        s_next.rresp = axis_bank_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign irq = s_reg.irq;
endmodule

// ---- axis_bank_assertions.sv ----
module axis_bank_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] jog_forward,
  input wire logic [7:0] jog_reverse,
  input wire logic [7:0] feed_update,
  input wire logic [7:0] loop_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data held too long");
  property p_feed;
    feed_update != 8'h00 |=> feed_update == 8'h00;
  endproperty
  a_feed: assert property (p_feed) else $error("feed update not a pulse");
  property p_jog_f;
    $changed(jog_forward) |=> $stable(jog_forward) [*8];
  endproperty
  a_jog_f: assert property (p_jog_f) else $error("forward jog fetched too often");
  property p_jog_r;
    $changed(jog_reverse) |=> $stable(jog_reverse) [*8];
  endproperty
  a_jog_r: assert property (p_jog_r) else $error("reverse jog fetched too often");
  property p_loop;
    $changed(loop_select) |=> $stable(loop_select) [*2];
  endproperty
  a_loop: assert property (p_loop) else $error("loop select off cycle");
endmodule

// ---- axis_bank_pkg.sv ----
package axis_bank_pkg;
  localparam int ADDR_W = 12;
  localparam int NAXES = 8;
  localparam int BLK_W = 20;
  localparam int NPINS = 8;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] START_OFS = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [11:0] CMD_BASE = 12'h100;
  localparam logic [11:0] STAT_BASE = 12'h200;
  localparam int REGION_LSB = 7;
  localparam int IDX_W = 5;
  localparam int CTRL_VIRT_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_MAX = 3'h4;
  localparam logic [2:0] SEL_SLOW = 3'h4;
  localparam logic [2:0] SLOW_MASK = 3'h7;
  localparam logic [4:0] MAIN_MASK = 5'h1F;
  localparam int TICK_W = 5;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_BASE_NS = 440000;
  localparam int BASE_TICK_CYC = OP_BASE_NS / CLK_PERIOD_NS;
  localparam int BASE_CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Command block bit positions
  localparam int C_STOP = 0;
  localparam int C_RAPID_STOP = 1;
  localparam int C_JOG_FWD = 2;
  localparam int C_JOG_REV = 3;
  localparam int C_CPL_CLR = 4;
  localparam int C_ERR_RST = 7;
  localparam int C_SERVO_RST = 8;
  localparam int C_EXT_DIS = 9;
  localparam int C_FEED_UPD = 12;
  localparam int C_CLUTCH_REF = 13;
  localparam int C_CAM_REF = 14;
  localparam int C_GAIN = 16;
  localparam int C_LOOP = 18;
  // Status block bit positions
  localparam int S_START_CPL = 0;
  localparam int S_POS_CPL = 1;
  localparam int S_SPEED = 4;
  localparam int S_ERR = 7;
  localparam int S_SERVO_ERR = 8;
  localparam int S_EXT_LSB = 11;
  localparam int S_READY = 15;
  // Pin vector positions
  localparam int P_UPPER = 0;
  localparam int P_LOWER = 1;
  localparam int P_STOP = 2;
  localparam int P_PROX = 3;
  localparam int P_READY = 4;
  localparam int P_ALARM = 5;
  localparam int P_FAULT = 6;
  localparam int P_DONE = 7;
endpackage

// ---- axis_bank_tb.sv ----
module axis_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} note_t;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [1:0] OK = axis_bank_pkg::RESP_OKAY;
  localparam logic [1:0] ER = axis_bank_pkg::RESP_SLVERR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [7:0] upper_stroke_limit_input, lower_stroke_limit_input, stop_input;
  logic [7:0] proximity_or_switch_input, servo_ready_input, servo_alarm_input;
  logic [7:0] fault_input, motion_done_input, jog_forward, jog_reverse, stop_request;
  logic [7:0] feed_update, clutch_ref_set, cam_ref_set, gain_select, loop_select;
  logic [7:0] fault_cmd = 8'h00, alarm_cmd = 8'h00, stop_cmd = 8'h00;
  note_t notes[$];
  note_t n;
  int err_count = 0, checks = 0, cyc = 0, feed_seen = 0;
  axis_bank #(.BASE_TICK_CYC(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .upper_stroke_limit_input, .lower_stroke_limit_input, .stop_input,
    .proximity_or_switch_input, .servo_ready_input, .servo_alarm_input, .fault_input,
    .motion_done_input, .jog_forward, .jog_reverse, .stop_request, .feed_update,
    .clutch_ref_set, .cam_ref_set, .gain_select, .loop_select, .irq);
  axis_plant_model i_plant (.aclk, .jog_forward, .jog_reverse, .fault_cmd, .alarm_cmd,
    .stop_cmd, .upper_stroke_limit_input, .lower_stroke_limit_input, .stop_input,
    .proximity_or_switch_input, .servo_ready_input, .servo_alarm_input, .fault_input,
    .motion_done_input);
  always #10 aclk = ~aclk;
  function automatic logic [11:0] ca(input int k);
    return axis_bank_pkg::CMD_BASE + 12'(4 * (k - 1));
  endfunction
  function automatic logic [11:0] sa(input int k);
    return axis_bank_pkg::STAT_BASE + 12'(4 * (k - 1));
  endfunction
  function automatic logic ob(input int w, input int ax);
    case (w)
      0: return jog_forward[ax];
      1: return jog_reverse[ax];
      2: return stop_request[ax];
      3: return clutch_ref_set[ax];
      4: return cam_ref_set[ax];
      5: return gain_select[ax];
      6: return loop_select[ax];
      default: return irq;
    endcase
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %0s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic note(input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    notes.push_back(note_t'{e, m, r});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    logic auxiliary_code_finish;
    auxiliary_code_finish = 1'h0;
    note(32'h0, 32'h0, r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!auxiliary_code_finish) begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      auxiliary_code_finish = (s_axi_bvalid === 1'h1);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic [1:0] r);
    logic auxiliary_code_finish;
    auxiliary_code_finish = 1'h0;
    note(e, m, r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!auxiliary_code_finish) begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      auxiliary_code_finish = (s_axi_rvalid === 1'h1);
    end
  endtask
  task automatic wt(input int w, input int ax, input logic v, input int lim);
    int k;
    k = 0;
    while (ob(w, ax) !== v && k < lim) begin
      @(posedge aclk);
      k++;
    end
    cmp(32'(ob(w, ax)), 32'(v), "output level");
  endtask
  // Result monitor and timeout
  always @(posedge aclk) begin
    cyc++;
    if (feed_update[4] === 1'h1) feed_seen++;
    if (s_axi_bvalid === 1'h1 || s_axi_rvalid === 1'h1) begin
      n = notes.pop_front();
      if (s_axi_bvalid === 1'h1) begin
        cmp(32'(s_axi_bresp), 32'(n.r), "write resp");
      end else begin
        cmp(s_axi_rdata & n.m, n.e, "read data");
        cmp(32'(s_axi_rresp), 32'(n.r), "read resp");
      end
    end
    if (cyc == 12000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(79976));
    idle(10);
    aresetn <= 1'h1;
    idle(2);
    rd(axis_bank_pkg::CTRL_OFS, 32'h0, ALL, OK);
    rd(axis_bank_pkg::IRQ_MASK_OFS, 32'h0, ALL, OK);
    rd(12'h010, 32'h0, ALL, ER);
    wr(12'h010, 32'h1, ER);
    wr(ca(9), 32'h3, OK);
    rd(ca(9), 32'h0, ALL, OK);
    rd(sa(9), 32'h0, ALL, OK);
    for (int i = 1; i <= 8; i++) begin
      d = $urandom() & 32'hFFFD93B0;
      wr(ca(i), d, OK);
      rd(ca(i), d & 32'h000D93B0, ALL, OK);
      wr(ca(i), 32'h0, OK);
    end
    $display("test map done");
    wr(ca(1), 32'h4, OK);
    wt(0, 0, 1'h1, 140);
    wr(ca(2), 32'h8, OK);
    wt(1, 1, 1'h1, 140);
    wr(ca(1), 32'h0, OK);
    wr(ca(2), 32'h0, OK);
    wt(0, 0, 1'h0, 140);
    wt(1, 1, 1'h0, 140);
    $display("test jog done");
    alarm_cmd <= 8'h04;
    idle(20);
    rd(sa(3), 32'h100, 32'h100, OK);
    alarm_cmd <= 8'h00;
    idle(10);
    wr(ca(3), 32'h100, OK);
    idle(140);
    rd(sa(3), 32'h0, 32'h100, OK);
    wr(ca(3), 32'h0, OK);
    fault_cmd <= 8'h08;
    idle(5);
    rd(sa(4), 32'h80, 32'h80, OK);
    rd(axis_bank_pkg::IRQ_STAT_OFS, 32'h8, ALL, OK);
    wt(7, 0, 1'h0, 0);
    wr(axis_bank_pkg::IRQ_MASK_OFS, 32'h8, OK);
    wt(7, 0, 1'h1, 3);
    fault_cmd <= 8'h00;
    wr(axis_bank_pkg::IRQ_STAT_OFS, 32'h8, OK);
    wt(7, 0, 1'h0, 3);
    $display("test error done");
    wr(ca(5), 32'h1000, OK);
    idle(140);
    cmp(feed_seen, 32'h0, "feed before start");
    wr(axis_bank_pkg::START_OFS, 32'h10, OK);
    idle(5);
    cmp(feed_seen, 32'h1, "feed at start");
    rd(sa(5), 32'h1, 32'h1, OK);
    wr(ca(5), 32'h10, OK);
    idle(140);
    rd(sa(5), 32'h0, 32'h1, OK);
    wr(ca(6), 32'h200, OK);
    wr(axis_bank_pkg::START_OFS, 32'h60, OK);
    wr(ca(6), 32'h0, OK);
    stop_cmd <= 8'h60;
    idle(8);
    wt(2, 6, 1'h1, 0);
    wt(2, 5, 1'h0, 0);
    stop_cmd <= 8'h00;
    $display("test start done");
    wr(ca(1), 32'h6000, OK);
    idle(10);
    wt(3, 0, 1'h0, 0);
    wr(axis_bank_pkg::CTRL_OFS, 32'h1, OK);
    wt(3, 0, 1'h1, 5);
    wt(4, 0, 1'h1, 5);
    wr(axis_bank_pkg::CTRL_OFS, 32'h0, OK);
    wr(ca(1), 32'h0, OK);
    idle(140);
    wt(4, 0, 1'h1, 0);
    wr(ca(8), 32'h50000, OK);
    wt(6, 7, 1'h1, 10);
    wt(5, 7, 1'h1, 10);
    wr(axis_bank_pkg::CTRL_OFS, 32'h8, OK);
    wr(ca(8), 32'h0, OK);
    wt(5, 7, 1'h0, 40);
    wt(6, 7, 1'h0, 80);
    $display("test cycle done");
    close_out();
  end
endmodule
bind axis_bank axis_bank_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .jog_forward, .jog_reverse, .feed_update, .loop_select);

// ---- axis_link_if.sv ----
interface axis_link_if;
  logic [axis_bank_pkg::BLK_W-1:0] cmd;
  logic [axis_bank_pkg::BLK_W-1:0] status;
  logic op_tick;
  logic main_tick;
  logic gain_tick;
  logic virt_enter;
  logic start;
  logic err_evt;
  modport bank (output cmd, op_tick, main_tick, gain_tick, virt_enter, start,
    input status, err_evt);
  modport axis (input cmd, op_tick, main_tick, gain_tick, virt_enter, start,
    output status, err_evt);
endinterface

// ---- axis_plant_model.sv ----
module axis_plant_model (
  input wire logic aclk,
  input wire logic [7:0] jog_forward,
  input wire logic [7:0] jog_reverse,
  input wire logic [7:0] fault_cmd,
  input wire logic [7:0] alarm_cmd,
  input wire logic [7:0] stop_cmd,
  output logic [7:0] upper_stroke_limit_input,
  output logic [7:0] lower_stroke_limit_input,
  output logic [7:0] stop_input,
  output logic [7:0] proximity_or_switch_input,
  output logic [7:0] servo_ready_input,
  output logic [7:0] servo_alarm_input,
  output logic [7:0] fault_input,
  output logic [7:0] motion_done_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // Axis reports done when idle, proximity follows forward jog
  always @(posedge aclk) begin
    motion_done_input <= ~(jog_forward | jog_reverse);
    proximity_or_switch_input <= jog_forward;
  end
  assign upper_stroke_limit_input = 8'h00;
  assign lower_stroke_limit_input = 8'h00;
  assign servo_ready_input = 8'hFF;
  assign servo_alarm_input = alarm_cmd;
  assign fault_input = fault_cmd;
  assign stop_input = stop_cmd;
endmodule

// ---- axis_unit.sv ----
module axis_unit (
  input wire logic aclk,
  input wire logic aresetn,
  axis_link_if.axis lk,
  input wire logic [axis_bank_pkg::NPINS-1:0] pins,
  output logic jog_fwd,
  output logic jog_rev,
  output logic stop_req,
  output logic feed_upd,
  output logic clutch_ref,
  output logic cam_ref,
  output logic gain_sel,
  output logic loop_sel
);
  typedef struct packed {
    logic [axis_bank_pkg::NPINS-1:0] sync1;
    logic [axis_bank_pkg::NPINS-1:0] sync2;
    logic [axis_bank_pkg::BLK_W-1:0] status;
    logic err_evt;
    logic jog_f;
    logic jog_r;
    logic ext_ign;
    logic stop;
    logic feed;
    logic clutch;
    logic cam;
    logic gain;
    logic loop;
  } ax_t;

  ax_t s_reg;
  ax_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;
    s_next.feed = 1'b0;
    s_next.err_evt = s_reg.sync2[axis_bank_pkg::P_FAULT] & ~s_reg.status[axis_bank_pkg::S_ERR];
    if (lk.main_tick) begin
      s_next.jog_f = lk.cmd[axis_bank_pkg::C_JOG_FWD]; // see [RULE_01]
      s_next.jog_r = lk.cmd[axis_bank_pkg::C_JOG_REV]; // see [RULE_02]
      s_next.status[axis_bank_pkg::S_EXT_LSB +: 4] = s_reg.sync2[axis_bank_pkg::P_PROX:0];
      if (lk.cmd[axis_bank_pkg::C_CPL_CLR]) begin
        s_next.status[axis_bank_pkg::S_START_CPL] = 1'b0; // see [RULE_03]
        s_next.status[axis_bank_pkg::S_POS_CPL] = 1'b0; // see [RULE_03]
      end
      if (lk.cmd[axis_bank_pkg::C_ERR_RST]) begin
        s_next.status[axis_bank_pkg::S_ERR] = 1'b0;
      end
      if (lk.cmd[axis_bank_pkg::C_SERVO_RST]) begin
        s_next.status[axis_bank_pkg::S_SERVO_ERR] = 1'b0; // see [RULE_04]
      end
    end
    if (lk.op_tick) begin
      s_next.status[axis_bank_pkg::S_SPEED] = s_reg.jog_f | s_reg.jog_r; // see [RULE_13]
      s_next.status[axis_bank_pkg::S_READY] = s_reg.sync2[axis_bank_pkg::P_READY];
      s_next.loop = lk.cmd[axis_bank_pkg::C_LOOP]; // see [RULE_10]
      if (s_reg.sync2[axis_bank_pkg::P_ALARM]) begin
        s_next.status[axis_bank_pkg::S_SERVO_ERR] = 1'b1;
      end
      if (s_reg.sync2[axis_bank_pkg::P_DONE]) begin
        s_next.status[axis_bank_pkg::S_POS_CPL] = 1'b1;
      end
    end
    if (lk.gain_tick) begin
      s_next.gain = lk.cmd[axis_bank_pkg::C_GAIN]; // see [RULE_11]
    end
    if (lk.start) begin
      s_next.status[axis_bank_pkg::S_START_CPL] = 1'b1;
      s_next.ext_ign = lk.cmd[axis_bank_pkg::C_EXT_DIS]; // see [RULE_05]
      s_next.feed = lk.cmd[axis_bank_pkg::C_FEED_UPD]; // see [RULE_06]
    end
    if (lk.virt_enter) begin
      s_next.clutch = lk.cmd[axis_bank_pkg::C_CLUTCH_REF]; // see [RULE_07]
      s_next.cam = lk.cmd[axis_bank_pkg::C_CAM_REF]; // see [RULE_08]
    end
    if (s_reg.sync2[axis_bank_pkg::P_FAULT]) begin
      s_next.status[axis_bank_pkg::S_ERR] = 1'b1; // see [RULE_13]
    end
    s_next.stop = lk.cmd[axis_bank_pkg::C_STOP] | lk.cmd[axis_bank_pkg::C_RAPID_STOP]
      | (s_reg.sync2[axis_bank_pkg::P_STOP] & ~s_reg.ext_ign); // see [RULE_05]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lk.status = s_reg.status;
  assign lk.err_evt = s_reg.err_evt;
  assign jog_fwd = s_reg.jog_f;
  assign jog_rev = s_reg.jog_r;
  assign stop_req = s_reg.stop;
  assign feed_upd = s_reg.feed;
  assign clutch_ref = s_reg.clutch;
  assign cam_ref = s_reg.cam;
  assign gain_sel = s_reg.gain;
  assign loop_sel = s_reg.loop;
endmodule
